// *** hdl/loop_mode_regs.sv ***
`include "loop_mode_params.svh"
// Behaviour
// - bumpless variant and direct/reverse action select
// - position or velocity output calculation select
// - square root pv, squared error options
// - error deadband and derivative gain limiting
// - bias integrator freeze when set
// - ramp/soak and pv level alarm enables
// - deviation and rate-of-change alarm enables
// - loop runs independent of controller mode
// - input/output polarity and 12/15-bit width
// - 16-bit select overrides polarity and width
// - separate select splits input and output formats
// - output 16-bit overrides output polarity/width
// - analog input filter and setpoint limiting
// - integral time units seconds or minutes
// - autotune options; start bit cleared when done
// - scan clock bit is read-only, internal
// - monitor shows active manual/auto/cascade mode
// - monitor reports pv level alarms
// - monitor reports deviation and rate alarms
// - monitor reports programming and overflow errors
// - monitor reports autotune busy and error
module loop_mode_regs
#(
  parameter logic [15:0] SCAN_HALF = `LM_SCAN_HALF_CYCLES
)
(
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // controller and loop engine status
  input wire logic cpu_run,
  input wire logic pv_low_low,
  input wire logic pv_low,
  input wire logic pv_high,
  input wire logic pv_high_high,
  input wire logic dev_yellow,
  input wire logic dev_red,
  input wire logic rate_alarm,
  input wire logic alarm_prog_error,
  input wire logic calc_overflow,
  input wire logic tune_done,
  input wire logic tune_failed,
  // decoded configuration toward the loop engine
  output logic loop_mode_manual,
  output logic loop_mode_auto,
  output logic loop_mode_cascade,
  output logic loop_enable,
  output logic bumpless_second,
  output logic reverse_acting,
  output logic velocity_form,
  output logic pv_square_root,
  output logic error_squared,
  output logic deadband_en,
  output logic dgain_limit_en,
  output logic bias_freeze,
  output logic ramp_soak_en,
  output logic pv_alarm_en,
  output logic dev_alarm_en,
  output logic rate_alarm_en,
  output logic in_bipolar,
  output logic in_15bit,
  output logic in_16bit,
  output logic out_bipolar,
  output logic out_15bit,
  output logic out_16bit,
  output logic input_filter_en,
  output logic sp_limit_en,
  output logic reset_minutes,
  output logic tune_open_loop,
  output logic tune_pi_only,
  output logic tune_start,
  output logic scan_clock
);

  loop_mode_pkg::lm_state_t state_reg;
  loop_mode_pkg::lm_state_t state_next;
  logic [15:0] monitor_word;
  logic addr_take;

  // an address phase is taken only when the bus is ready and the transfer is real
  assign addr_take = hsel && hready && (htrans == `LM_HTRANS_NONSEQ || htrans == `LM_HTRANS_SEQ);

  // monitoring word assembled from live state
  always_comb
  begin
    monitor_word = 16'h0000;
    monitor_word[`LM_MON_MODE_LSB +: 3] = state_reg.mode;
    // level alarms, shown only while level monitoring is on
    monitor_word[`LM_MON_LOW_LOW] = pv_low_low && state_reg.cfg_one[`LM_C1_PV_ALARM];
    monitor_word[`LM_MON_LOW] = pv_low && state_reg.cfg_one[`LM_C1_PV_ALARM];
    monitor_word[`LM_MON_HIGH] = pv_high && state_reg.cfg_one[`LM_C1_PV_ALARM];
    monitor_word[`LM_MON_HIGH_HIGH] = pv_high_high && state_reg.cfg_one[`LM_C1_PV_ALARM];
    // deviation and rate alarms gated by their enables
    monitor_word[`LM_MON_YELLOW] = dev_yellow && state_reg.cfg_one[`LM_C1_DEV_ALARM];
    monitor_word[`LM_MON_RED] = dev_red && state_reg.cfg_one[`LM_C1_DEV_ALARM];
    monitor_word[`LM_MON_ROC] = rate_alarm && state_reg.cfg_one[`LM_C1_ROC_ALARM];
    monitor_word[`LM_MON_PROG_ERR] = alarm_prog_error;
    monitor_word[`LM_MON_OVERFLOW] = calc_overflow;
    monitor_word[`LM_MON_TUNING] = state_reg.tune_busy;
    monitor_word[`LM_MON_TUNE_ERR] = state_reg.tune_err;
  end

  // next state: engine events first, then the bus write, so a write wins a tie
  always_comb
  begin
    state_next = state_reg;
    state_next.tune_pulse = 1'b0;
    // a pending request moves the loop mode, manual taking priority
    if (state_reg.cfg_one[`LM_C1_REQ_MANUAL])
      state_next.mode = loop_mode_pkg::MODE_MANUAL;
    else if (state_reg.cfg_one[`LM_C1_REQ_AUTO])
      state_next.mode = loop_mode_pkg::MODE_AUTO;
    else if (state_reg.cfg_one[`LM_C1_REQ_CASCADE])
      state_next.mode = loop_mode_pkg::MODE_CASCADE;
    // requests are consumed one cycle after they land
    state_next.cfg_one[`LM_C1_REQ_CASCADE:`LM_C1_REQ_MANUAL] = 3'h0;
    // end of tuning returns the start bit to zero
    if (tune_done && state_reg.tune_busy)
    begin
      state_next.cfg_two[`LM_C2_TUNE_START] = 1'b0;
      state_next.tune_busy = 1'b0;
      state_next.tune_err = tune_failed;
    end
    // internal scan clock divider, not writable from the bus
    if (state_reg.scan_cnt >= SCAN_HALF - `LM_SCAN_ONE)
    begin
      state_next.scan_cnt = `LM_SCAN_RESET;
      state_next.scan_clk = ~state_reg.scan_clk;
    end
    else
    begin
      state_next.scan_cnt = state_reg.scan_cnt + `LM_SCAN_ONE;
    end
    // bus data phase write
    if (state_reg.dp_sel && state_reg.dp_write)
    begin
      unique case (state_reg.dp_idx)
        `LM_IDX_CFG_ONE:
        begin
          state_next.cfg_one = hwdata[15:0];
        end
        `LM_IDX_CFG_TWO:
        begin
          // reserved and read-only bits keep their value
          state_next.cfg_two = (hwdata[15:0] & `LM_CFG_TWO_WMASK)
                             | (state_next.cfg_two & ~`LM_CFG_TWO_WMASK);
          // a fresh start launches tuning and clears an old error
          if (hwdata[`LM_C2_TUNE_START] && !state_reg.tune_busy)
          begin
            state_next.tune_busy = 1'b1;
            state_next.tune_err = 1'b0;
            state_next.tune_pulse = 1'b1;
          end
          else if (hwdata[`LM_C2_TUNE_START])
          begin
            // a rewrite while tuning keeps the bit set and the run going
            state_next.tune_busy = 1'b1;
          end
        end
        default:
        begin
          // monitor and unmapped words ignore writes
        end
      endcase
    end
    // bit 8 always mirrors the scan clock
    state_next.cfg_two[`LM_C2_SCAN_CLK] = state_next.scan_clk;
    // address phase bookkeeping
    state_next.dp_sel = addr_take;
    state_next.dp_write = hwrite;
    state_next.dp_idx = haddr[`LM_IDX_MSB:`LM_IDX_LSB];
    // read data captured from the post-write view, so back-to-back reads see writes
    state_next.rdata = 32'h0000_0000;
    if (addr_take && !hwrite && haddr[31:`LM_IDX_MSB + 1] == '0)
    begin
      unique case (haddr[`LM_IDX_MSB:`LM_IDX_LSB])
        `LM_IDX_CFG_ONE: state_next.rdata = {16'h0000, state_next.cfg_one};
        `LM_IDX_CFG_TWO: state_next.rdata = {16'h0000, state_next.cfg_two};
        // reserved monitor bits are never set
        `LM_IDX_MONITOR: state_next.rdata = {16'h0000, monitor_word};
        default: state_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  // single state register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg.cfg_one <= `LM_CFG_ONE_RESET;
      state_reg.cfg_two <= `LM_CFG_TWO_RESET;
      state_reg.mode <= loop_mode_pkg::MODE_MANUAL;
      state_reg.tune_busy <= 1'b0;
      state_reg.tune_err <= 1'b0;
      state_reg.tune_pulse <= 1'b0;
      state_reg.scan_cnt <= `LM_SCAN_RESET;
      state_reg.scan_clk <= 1'b0;
      state_reg.dp_write <= 1'b0;
      state_reg.dp_sel <= 1'b0;
      state_reg.dp_idx <= 4'h0;
      state_reg.rdata <= 32'h0000_0000;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // bus answers: zero wait states, always okay
  assign hrdata = state_reg.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // mode and run control
  assign loop_mode_manual = state_reg.mode == loop_mode_pkg::MODE_MANUAL;
  assign loop_mode_auto = state_reg.mode == loop_mode_pkg::MODE_AUTO;
  assign loop_mode_cascade = state_reg.mode == loop_mode_pkg::MODE_CASCADE;
  // independent loops ignore the controller run state
  assign loop_enable = state_reg.cfg_one[`LM_C1_INDEPENDENT] || cpu_run;

  assign bumpless_second = state_reg.cfg_one[`LM_C1_BUMPLESS];
  assign reverse_acting = state_reg.cfg_one[`LM_C1_REVERSE];
  assign velocity_form = state_reg.cfg_one[`LM_C1_VELOCITY];
  assign pv_square_root = state_reg.cfg_one[`LM_C1_PV_SQRT];
  assign error_squared = state_reg.cfg_one[`LM_C1_ERR_SQUARED];
  assign deadband_en = state_reg.cfg_one[`LM_C1_DEADBAND];
  assign dgain_limit_en = state_reg.cfg_one[`LM_C1_DGAIN_LIMIT];
  assign bias_freeze = state_reg.cfg_one[`LM_C1_BIAS_FREEZE];
  assign ramp_soak_en = state_reg.cfg_one[`LM_C1_RAMP_SOAK];
  assign pv_alarm_en = state_reg.cfg_one[`LM_C1_PV_ALARM];
  assign dev_alarm_en = state_reg.cfg_one[`LM_C1_DEV_ALARM];
  assign rate_alarm_en = state_reg.cfg_one[`LM_C1_ROC_ALARM];

  // input format: the 16-bit select forces unipolar and hides the width bit
  assign in_16bit = state_reg.cfg_two[`LM_C2_IN_16BIT];
  assign in_bipolar = state_reg.cfg_two[`LM_C2_IN_BIPOLAR] && !in_16bit;
  assign in_15bit = state_reg.cfg_two[`LM_C2_IN_15BIT] && !in_16bit;

  // output format follows the input unless separate formats are chosen
  always_comb
  begin
    if (!state_reg.cfg_two[`LM_C2_SEPARATE])
    begin
      out_16bit = in_16bit;
      out_bipolar = in_bipolar;
      out_15bit = in_15bit;
    end
    else
    begin
      out_16bit = state_reg.cfg_two[`LM_C2_OUT_16BIT];
      out_bipolar = state_reg.cfg_two[`LM_C2_OUT_BIPOLAR] && !out_16bit;
      out_15bit = state_reg.cfg_two[`LM_C2_OUT_15BIT] && !out_16bit;
    end
  end

  assign input_filter_en = state_reg.cfg_two[`LM_C2_FILTER];
  assign sp_limit_en = state_reg.cfg_two[`LM_C2_SP_LIMIT];
  assign reset_minutes = state_reg.cfg_two[`LM_C2_MINUTES];
  assign tune_open_loop = state_reg.cfg_two[`LM_C2_TUNE_OPEN];
  assign tune_pi_only = state_reg.cfg_two[`LM_C2_TUNE_PI];
  assign tune_start = state_reg.tune_pulse;
  assign scan_clock = state_reg.scan_clk;

endmodule

// *** hdl/loop_mode_params.svh ***
`ifndef LOOP_MODE_PARAMS_SVH
`define LOOP_MODE_PARAMS_SVH

// register indices as printed, byte address is four times the index
`define LM_IDX_CFG_ONE 4'h0
`define LM_IDX_CFG_TWO 4'h1
`define LM_IDX_MONITOR 4'h6
`define LM_IDX_LSB 2
`define LM_IDX_MSB 5

// reset values
`define LM_CFG_ONE_RESET 16'h0000
`define LM_CFG_TWO_RESET 16'h0000
`define LM_SCAN_RESET 16'h0000

// writable bits of configuration word two: bit 8 and bits 14..15 excluded
`define LM_CFG_TWO_WMASK 16'h3eff

// configuration word one fields
`define LM_C1_REQ_MANUAL 0
`define LM_C1_REQ_AUTO 1
`define LM_C1_REQ_CASCADE 2
`define LM_C1_BUMPLESS 3
`define LM_C1_REVERSE 4
`define LM_C1_VELOCITY 5
`define LM_C1_PV_SQRT 6
`define LM_C1_ERR_SQUARED 7
`define LM_C1_DEADBAND 8
`define LM_C1_DGAIN_LIMIT 9
`define LM_C1_BIAS_FREEZE 10
`define LM_C1_RAMP_SOAK 11
`define LM_C1_PV_ALARM 12
`define LM_C1_DEV_ALARM 13
`define LM_C1_ROC_ALARM 14
`define LM_C1_INDEPENDENT 15

// configuration word two fields
`define LM_C2_IN_BIPOLAR 0
`define LM_C2_IN_15BIT 1
`define LM_C2_FILTER 2
`define LM_C2_SP_LIMIT 3
`define LM_C2_MINUTES 4
`define LM_C2_TUNE_OPEN 5
`define LM_C2_TUNE_PI 6
`define LM_C2_TUNE_START 7
`define LM_C2_SCAN_CLK 8
`define LM_C2_IN_16BIT 9
`define LM_C2_SEPARATE 10
`define LM_C2_OUT_BIPOLAR 11
`define LM_C2_OUT_15BIT 12
`define LM_C2_OUT_16BIT 13

// monitoring word fields
`define LM_MON_MODE_LSB 0
`define LM_MON_LOW_LOW 3
`define LM_MON_LOW 4
`define LM_MON_HIGH 5
`define LM_MON_HIGH_HIGH 6
`define LM_MON_YELLOW 7
`define LM_MON_RED 8
`define LM_MON_ROC 9
`define LM_MON_PROG_ERR 10
`define LM_MON_OVERFLOW 11
`define LM_MON_TUNING 12
`define LM_MON_TUNE_ERR 13

// half period of the internal scan clock, in hclk cycles
`define LM_SCAN_HALF_CYCLES 16'h0010
`define LM_SCAN_ONE 16'h0001

// ahb-lite codes
`define LM_HTRANS_NONSEQ 2'h2
`define LM_HTRANS_SEQ 2'h3

`endif

// *** hdl/loop_mode_pkg.sv ***
package loop_mode_pkg;

  // active loop mode, one-hot so the codes map straight onto the monitor bits
  typedef enum logic [2:0]
  {
    MODE_MANUAL = 3'h1,
    MODE_AUTO = 3'h2,
    MODE_CASCADE = 3'h4
  } loop_mode_t;

  typedef struct packed {
    logic [15:0] cfg_one;
    logic [15:0] cfg_two;
    loop_mode_t mode;
    logic tune_busy;
    logic tune_err;
    logic tune_pulse;
    logic [15:0] scan_cnt;
    logic scan_clk;
    logic dp_write;
    logic dp_sel;
    logic [3:0] dp_idx;
    logic [31:0] rdata;
  } lm_state_t;

endpackage

// *** verif/loop_mode_regs_checker.sv ***
module loop_mode_checker
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic cpu_run,
  input wire logic loop_enable,
  input wire logic loop_mode_manual,
  input wire logic loop_mode_auto,
  input wire logic loop_mode_cascade,
  input wire logic reverse_acting,
  input wire logic in_bipolar,
  input wire logic in_15bit,
  input wire logic in_16bit,
  input wire logic out_bipolar,
  input wire logic out_15bit,
  input wire logic out_16bit,
  input wire logic tune_start,
  input wire logic pv_low_low,
  input wire logic pv_high_high,
  input wire logic pv_alarm_en
);
  logic take;
  logic low;
  logic wr_one;
  logic rd_hi;
  logic rd_mon;
  // address phase decode, so the following data phase can be judged
  assign take = hsel && hready && htrans[1] && haddr[31:6] == 26'h0;
  assign low = haddr[5:2] == 4'h0;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // remember which transfer owns the coming data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_one <= 1'h0;
      rd_hi <= 1'h0;
      rd_mon <= 1'h0;
    end
    else
    begin
      wr_one <= take && hwrite && low;
      rd_hi <= take && !hwrite && (haddr[5:2] == 4'h1 || haddr[5:2] == 4'h6);
      rd_mon <= take && !hwrite && haddr[5:2] == 4'h6;
    end
  end
  run_enable_a: assert property (cpu_run |-> loop_enable)
    else $error("loop stopped while controller runs");
  mode_onehot_a: assert property ($onehot({loop_mode_manual, loop_mode_auto, loop_mode_cascade}))
    else $error("active mode not one-hot");
  in_format_a: assert property (in_16bit |-> !in_bipolar && !in_15bit)
    else $error("input 16-bit not unipolar");
  out_format_a: assert property (out_16bit |-> !out_bipolar && !out_15bit)
    else $error("output 16-bit not unipolar");
  tune_pulse_a: assert property (tune_start |=> !tune_start)
    else $error("tune start longer than one cycle");
  mode_request_a: assert property (wr_one && hwdata[2:0] == 3'h2 |-> ##[1:3] loop_mode_auto)
    else $error("auto request not taken");
  action_copy_a: assert property (wr_one |=> ##1 reverse_acting == $past(hwdata[4], 2))
    else $error("loop action does not follow write");
  reserved_zero_a: assert property (rd_hi |-> hrdata[31:14] == 18'h0)
    else $error("reserved bits read nonzero");
  level_alarm_a: assert property (rd_mon |-> hrdata[3] == $past(pv_low_low && pv_alarm_en)
    && hrdata[6] == $past(pv_high_high && pv_alarm_en))
    else $error("level alarm bits wrong");
  cover property (wr_one && hwdata[2:0] == 3'h2);
  cover property (tune_start);
  cover property (rd_mon && hrdata[3]);
endmodule

bind loop_mode_regs loop_mode_checker u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hready, .hwdata, .hrdata, .cpu_run, .loop_enable, .loop_mode_manual, .loop_mode_auto,
  .loop_mode_cascade, .reverse_acting, .in_bipolar, .in_15bit, .in_16bit, .out_bipolar,
  .out_15bit, .out_16bit, .tune_start, .pv_low_low, .pv_high_high, .pv_alarm_en);

// *** verif/loop_mode_regs_tb_top.sv ***
module loop_mode_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk, hresetn, hsel, hwrite, cpu_run, tune_done, tune_failed;
  logic hreadyout, hresp, loop_enable, tune_start, scan_clock;
  logic [1:0] htrans;
  logic [2:0] hsize, mode;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [8:0] alm;
  logic [11:0] c1o;
  logic [4:0] c2o;
  logic [5:0] fmt;
  int err_total, samples_checked;
  localparam logic [2:0] mreq [5] = '{3'h2, 3'h4, 3'h1, 3'h6, 3'h3};
  localparam logic [2:0] mexp [5] = '{3'h2, 3'h4, 3'h1, 3'h2, 3'h1};
  localparam logic [15:0] fval [5] = '{16'h0203, 16'h1401, 16'h3c03, 16'h0801, 16'hc103};
  localparam logic [5:0] fexp [5] = '{6'h24, 6'h11, 6'h23, 6'h09, 6'h1b};
  // scan clock shortened so its toggling shows in a short run
  loop_mode_regs #(.SCAN_HALF(16'h0004)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cpu_run(cpu_run),
    .pv_low_low(alm[0]), .pv_low(alm[1]), .pv_high(alm[2]), .pv_high_high(alm[3]),
    .dev_yellow(alm[4]), .dev_red(alm[5]), .rate_alarm(alm[6]), .alarm_prog_error(alm[7]),
    .calc_overflow(alm[8]), .tune_done(tune_done), .tune_failed(tune_failed),
    .loop_mode_manual(mode[0]), .loop_mode_auto(mode[1]), .loop_mode_cascade(mode[2]),
    .loop_enable(loop_enable), .bumpless_second(c1o[0]), .reverse_acting(c1o[1]),
    .velocity_form(c1o[2]), .pv_square_root(c1o[3]), .error_squared(c1o[4]),
    .deadband_en(c1o[5]), .dgain_limit_en(c1o[6]), .bias_freeze(c1o[7]),
    .ramp_soak_en(c1o[8]), .pv_alarm_en(c1o[9]), .dev_alarm_en(c1o[10]),
    .rate_alarm_en(c1o[11]), .in_bipolar(fmt[0]), .in_15bit(fmt[1]), .in_16bit(fmt[2]),
    .out_bipolar(fmt[3]), .out_15bit(fmt[4]), .out_16bit(fmt[5]), .input_filter_en(c2o[0]),
    .sp_limit_en(c2o[1]), .reset_minutes(c2o[2]), .tune_open_loop(c2o[3]),
    .tune_pi_only(c2o[4]), .tune_start(tune_start), .scan_clock(scan_clock));
  task end_sim;
  begin
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
  begin
    samples_checked++;
    if (g !== e)
    begin
      err_total++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  end
  endtask
  // one single ahb-lite transfer; read data is stable through the data phase
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
  begin
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (!hreadyout);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    // read data taken at the edge that closes the data phase, before the slave moves on
    do @(posedge hclk); while (!hreadyout);
    rd = hrdata;
  end
  endtask
  task t_reset;
  begin
    bus(1'h0, 32'h0, 32'h0);
    chk("cfg1", 32'h0, rd);
    bus(1'h0, 32'h4, 32'h0);
    chk("cfg2", 32'h0, rd & 32'hfffffeff);
    bus(1'h0, 32'h18, 32'h0);
    chk("mon", 32'h1, rd);
  end
  endtask
  task t_cfg_one;
  begin
    bus(1'h1, 32'h0, 32'hfff8);
    repeat (2) @(negedge hclk);
    chk("c1o", 32'hfff, 32'(c1o));
    chk("run", 32'h1, 32'(loop_enable));
    bus(1'h0, 32'h0, 32'h0);
    chk("cfg1rd", 32'hfff8, rd);
    bus(1'h1, 32'h0, 32'h0028);
    repeat (2) @(negedge hclk);
    chk("c1o", 32'h005, 32'(c1o));
    chk("run", 32'h0, 32'(loop_enable));
    @(posedge hclk) cpu_run <= 1'h1;
    @(negedge hclk);
    chk("run", 32'h1, 32'(loop_enable));
  end
  endtask
  task t_modes;
  begin
    for (int i = 0; i < 5; i++)
    begin
      bus(1'h1, 32'h0, 32'(mreq[i]));
      repeat (2) @(posedge hclk);
      bus(1'h0, 32'h18, 32'h0);
      chk("monmode", 32'(mexp[i]), rd & 32'h7);
      chk("mode", 32'(mexp[i]), 32'(mode));
    end
  end
  endtask
  task t_formats;
  begin
    for (int i = 0; i < 5; i++)
    begin
      bus(1'h1, 32'h4, 32'(fval[i]));
      @(negedge hclk);
      chk("fmt", 32'(fexp[i]), 32'(fmt));
    end
    bus(1'h0, 32'h4, 32'h0);
    chk("cfg2rd", 32'h0003, rd & 32'hfffffeff);
    bus(1'h1, 32'h4, 32'h007c);
    @(negedge hclk);
    chk("c2o", 32'h1f, 32'(c2o));
  end
  endtask
  task t_tune;
  begin
    bus(1'h1, 32'h4, 32'h0080);
    @(negedge hclk);
    chk("start", 32'h1, 32'(tune_start));
    @(negedge hclk);
    chk("start", 32'h0, 32'(tune_start));
    bus(1'h0, 32'h18, 32'h0);
    chk("busy", 32'h1001, rd);
    bus(1'h0, 32'h4, 32'h0);
    chk("bit7", 32'h80, rd & 32'h80);
    @(posedge hclk);
    tune_done <= 1'h1;
    tune_failed <= 1'h1;
    @(posedge hclk);
    tune_done <= 1'h0;
    tune_failed <= 1'h0;
    bus(1'h0, 32'h4, 32'h0);
    chk("bit7", 32'h0, rd & 32'h80);
    bus(1'h0, 32'h18, 32'h0);
    chk("tuneerr", 32'h2001, rd);
  end
  endtask
  task t_alarms;
  begin
    bus(1'h1, 32'h0, 32'h7000);
    alm <= 9'h1ff;
    bus(1'h0, 32'h18, 32'h0);
    chk("alarms", 32'h2ff9, rd);
    bus(1'h1, 32'h0, 32'h0);
    bus(1'h0, 32'h18, 32'h0);
    chk("gated", 32'h2c01, rd);
    bus(1'h1, 32'h18, 32'hffff);
    chk("hresp", 32'h0, 32'(hresp));
    bus(1'h0, 32'h18, 32'h0);
    chk("ro", 32'h2c01, rd);
    bus(1'h0, 32'h0c, 32'h0);
    chk("unmapped", 32'h0, rd);
  end
  endtask
  // scan clock half period is four cycles here, so it flips after four and returns after eight
  task t_scan;
  logic s;
  begin
    @(negedge hclk);
    s = scan_clock;
    repeat (4) @(negedge hclk);
    chk("scan", 32'(!s), 32'(scan_clock));
    repeat (4) @(negedge hclk);
    chk("scan", 32'(s), 32'(scan_clock));
  end
  endtask
  initial
  begin
    hclk = 1'h0;
    forever #10 hclk = ~hclk;
  end
  // cut a hang short, over thirty times the expected run
  initial
  begin
    #100us;
    err_total++;
    end_sim();
  end
  initial
  begin
    {hresetn, hsel, hwrite, cpu_run, tune_done, tune_failed} = 6'h0;
    {htrans, hsize, haddr, hwdata, alm} = '0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'h1;
    t_reset();
    t_cfg_one();
    t_modes();
    t_formats();
    t_tune();
    t_alarms();
    t_scan();
    end_sim();
  end
endmodule
